// ==== rtl/cnled_coder.sv ====
// status lamp coder of a CAN coupler node with register slave
// How it works
// - bus lamp dark without error or search
// - baud search flashes bus lamp 50/50 ms
// - warning limit gives single 200/1000 ms blink
// - guard/heartbeat loss gives two blinks, pause
// - supervise only when configured times nonzero
// - supervision loss forces preop, stops PDOs, errors
// - sync loss after 1.5 periods, three blinks
// - event timer loss gives four blinks, preop
// - bus-off stops CAN, steady lamp until reset
// - node lamp dark while baud search runs
// - stopped state single flashes node lamp, dark when fw_old is set
// - preop blinks node lamp 200/200 ms
// - operational lights node lamp steadily
// - transmit queue overflow lights lamp until reset
// - logical transmit overflow blinks 200/200 ms
// - logical overflow held ten seconds, retriggerable
// - receive overflow steady, then blinks until reset
`include "cnled_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cnled_coder #(
    parameter int TICK_CYCLES = `CNLED_TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    // conditions from the protocol stack, same clock
    input wire logic baud_search,
    input wire logic warn_limit,
    input wire logic bus_off_event,
    input wire cnled_pkg::cnled_node_t node_state,
    input wire logic guard_rx,
    input wire logic hb_rx,
    input wire logic sync_rx,
    input wire logic rpdo_rx,
    input wire logic tx_queue_ovf,
    input wire logic tx_logic_ovf,
    input wire logic rx_queue_ovf,
    // reactions towards the stack and the outputs
    output logic preop_request,
    output logic pdo_stop,
    output logic outputs_error,
    output logic can_stop,
    // lamps
    output logic bus_fault_lamp,
    output logic node_state_lamp,
    output logic tx_ovf_lamp,
    output logic rx_ovf_lamp
);

////////////////////////////////////////////////////////////////////////////

    // byte lane merge for partial register writes
    function automatic logic [31:0] be_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // pattern length in ms; the counter wraps at this value
    function automatic logic [11:0] pat_len(input cnled_pkg::cnled_pat_t p);
        logic [11:0] l;
        l = 12'h001;
        case (p)
            cnled_pkg::PAT_FAST: l = 12'(2 * `CNLED_FAST_MS);
            cnled_pkg::PAT_SINGLE: l = 12'(`CNLED_BLINK_MS + `CNLED_PAUSE_MS);
            cnled_pkg::PAT_EVEN: l = 12'(2 * `CNLED_BLINK_MS);
            cnled_pkg::PAT_BLINK2:
                l = 12'(4 * `CNLED_BLINK_MS + `CNLED_PAUSE_MS);
            cnled_pkg::PAT_BLINK3:
                l = 12'(6 * `CNLED_BLINK_MS + `CNLED_PAUSE_MS);
            cnled_pkg::PAT_BLINK4:
                l = 12'(8 * `CNLED_BLINK_MS + `CNLED_PAUSE_MS);
            default: l = 12'h001;
        endcase
        return l;
    endfunction

    // lamp level of a pattern at ms position t, starting lit
    function automatic logic pat_lit(input cnled_pkg::cnled_pat_t p,
        input logic [11:0] t);
        logic o;
        logic [2:0] n;
        o = 1'b0;
        n = 3'h0;
        case (p)
            cnled_pkg::PAT_ON: o = 1'b1;
            cnled_pkg::PAT_FAST: o = t < 12'(`CNLED_FAST_MS);
            cnled_pkg::PAT_SINGLE: o = t < 12'(`CNLED_BLINK_MS);
            cnled_pkg::PAT_EVEN: o = t < 12'(`CNLED_BLINK_MS);
            cnled_pkg::PAT_BLINK2,
            cnled_pkg::PAT_BLINK3,
            cnled_pkg::PAT_BLINK4: begin
                n = (p == cnled_pkg::PAT_BLINK2) ? 3'h2 :
                    (p == cnled_pkg::PAT_BLINK3) ? 3'h3 : 3'h4;
                o = (t < 12'(2 * `CNLED_BLINK_MS) * 12'(n)) &&
                    ((t % 12'(2 * `CNLED_BLINK_MS)) < 12'(`CNLED_BLINK_MS));
            end
            default: o = 1'b0;
        endcase
        return o;
    endfunction

    // advance one lamp counter; restart on pattern change
    function automatic logic [11:0] pat_step(input cnled_pkg::cnled_pat_t old,
        input cnled_pkg::cnled_pat_t nw, input logic [11:0] t,
        input logic tick);
        logic [11:0] r;
        r = t;
        if (old != nw) begin
            r = 12'h000;
        end else if (tick) begin
            r = (t + 12'h001 >= pat_len(nw)) ? 12'h000 : t + 12'h001;
        end
        return r;
    endfunction

////////////////////////////////////////////////////////////////////////////

    cnled_pkg::cnled_state_t s;
    cnled_pkg::cnled_state_t next_s;
    logic [`CNLED_EV_WIDTH-1:0] ev;
    logic [23:0] life_ms;
    logic [16:0] sync_limit;
    logic guard_on;
    logic hb_on;
    logic guard_to;
    logic hb_to;
    logic sync_to;
    logic evt_to;
    logic sup_err;
    logic ltx_active;
    logic bus_req;
    logic [31:0] rmux;
    logic [31:0] wval;
    cnled_pkg::cnled_pat_t bus_pat_n;
    cnled_pkg::cnled_pat_t node_pat_n;
    cnled_pkg::cnled_pat_t tx_pat_n;
    cnled_pkg::cnled_pat_t rx_pat_n;

    // supervision thresholds; a zero setting disables that watchdog
    assign life_ms = 24'(s.guard_time) * 24'(s.life_factor);
    assign guard_on = (s.guard_time != 16'h0000) &&
        (s.life_factor != 8'h00);
    assign hb_on = s.hb_time != 16'h0000;
    assign sync_limit = 17'(s.sync_period) +
        17'(s.sync_period[15:1]);
    assign guard_to = guard_on && (s.guard_cnt >= life_ms);
    assign hb_to = hb_on && (s.hb_cnt >= s.hb_time);
    assign sync_to = (s.sync_period != 16'h0000) &&
        (s.sync_cnt >= sync_limit);
    assign evt_to = (s.event_time != 16'h0000) &&
        (s.evt_cnt >= s.event_time);
    assign sup_err = s.guard_err || s.sync_err || s.evt_err;
    assign ltx_active = s.ltx_hold != 14'h0000;
    assign bus_req = read || write;

    // register read view; unmapped offsets read zero
    always_comb begin
        rmux = 32'h0000_0000;
        case (address)
            `CNLED_REG_CTRL: rmux = {31'h0, s.fw_old};
            `CNLED_REG_GUARD_TIME: rmux = {16'h0, s.guard_time};
            `CNLED_REG_LIFE_FACTOR: rmux = {24'h0, s.life_factor};
            `CNLED_REG_HB_TIME: rmux = {16'h0, s.hb_time};
            `CNLED_REG_SYNC_PERIOD: rmux = {16'h0, s.sync_period};
            `CNLED_REG_EVENT_TIME: rmux = {16'h0, s.event_time};
            `CNLED_REG_STATUS: rmux = {12'h0, s.rx_lamp, s.tx_lamp,
                s.node_lamp, s.bus_lamp, 1'b0, s.rx_pat, 1'b0, s.tx_pat,
                1'b0, s.node_pat, 1'b0, s.bus_pat};
            `CNLED_REG_IRQ_STAT: rmux = {25'h0, s.irq_stat};
            `CNLED_REG_IRQ_MASK: rmux = {25'h0, s.irq_mask};
            default: rmux = 32'h0000_0000;
        endcase
    end

    // lamp pattern selection
    always_comb begin
        // most severe condition wins on the bus lamp
        if (s.bus_off) begin
            bus_pat_n = cnled_pkg::PAT_ON;
        end else if (s.evt_err) begin
            bus_pat_n = cnled_pkg::PAT_BLINK4;
        end else if (s.sync_err) begin
            bus_pat_n = cnled_pkg::PAT_BLINK3;
        end else if (s.guard_err) begin
            bus_pat_n = cnled_pkg::PAT_BLINK2;
        end else if (baud_search) begin
            bus_pat_n = cnled_pkg::PAT_FAST;
        end else if (warn_limit) begin
            bus_pat_n = cnled_pkg::PAT_SINGLE;
        end else begin
            bus_pat_n = cnled_pkg::PAT_OFF;
        end
        // supervision loss shows preop before the stack reacts
        if (baud_search) begin
            node_pat_n = cnled_pkg::PAT_OFF;
        end else if (sup_err) begin
            node_pat_n = cnled_pkg::PAT_EVEN;
        end else begin
            case (node_state)
                cnled_pkg::NODE_STOPPED: node_pat_n = s.fw_old ?
                    cnled_pkg::PAT_OFF : cnled_pkg::PAT_SINGLE;
                cnled_pkg::NODE_PREOP:
                    node_pat_n = cnled_pkg::PAT_EVEN;
                cnled_pkg::NODE_OPER:
                    node_pat_n = cnled_pkg::PAT_ON;
                default: node_pat_n = cnled_pkg::PAT_OFF;
            endcase
        end
        if (s.tx_ovf) begin
            tx_pat_n = cnled_pkg::PAT_ON;
        end else if (ltx_active) begin
            tx_pat_n = cnled_pkg::PAT_EVEN;
        end else begin
            tx_pat_n = cnled_pkg::PAT_OFF;
        end
        if (rx_queue_ovf) begin
            rx_pat_n = cnled_pkg::PAT_ON;
        end else if (s.rx_seen) begin
            rx_pat_n = cnled_pkg::PAT_EVEN;
        end else begin
            rx_pat_n = cnled_pkg::PAT_OFF;
        end
    end

    // events that raise sticky interrupt bits
    always_comb begin
        ev = '0;
        ev[`CNLED_EV_BUS_OFF] = bus_off_event && !s.bus_off;
        ev[`CNLED_EV_GUARD] = (guard_to || hb_to) && !s.guard_err;
        ev[`CNLED_EV_SYNC] = sync_to && !s.sync_err;
        ev[`CNLED_EV_EVENT] = evt_to && !s.evt_err;
        ev[`CNLED_EV_TX_OVF] = tx_queue_ovf;
        ev[`CNLED_EV_LTX_OVF] = tx_logic_ovf;
        ev[`CNLED_EV_RX_OVF] = rx_queue_ovf && !s.rx_seen;
    end

////////////////////////////////////////////////////////////////////////////

    // next state of the whole block
    always_comb begin
        next_s = s;
        wval = be_merge(rmux, writedata, byteenable);
        // bus slave: one wait cycle, write lands when waitrequest is low
        next_s.ack = bus_req && !s.ack;
        if (read && !s.ack) begin
            next_s.rdata = rmux;
        end
        next_s.irq_stat = s.irq_stat;
        if (write && s.ack) begin
            case (address)
                `CNLED_REG_CTRL: next_s.fw_old = wval[0];
                `CNLED_REG_GUARD_TIME: next_s.guard_time = wval[15:0];
                `CNLED_REG_LIFE_FACTOR: next_s.life_factor = wval[7:0];
                `CNLED_REG_HB_TIME: next_s.hb_time = wval[15:0];
                `CNLED_REG_SYNC_PERIOD: next_s.sync_period = wval[15:0];
                `CNLED_REG_EVENT_TIME: next_s.event_time = wval[15:0];
                `CNLED_REG_IRQ_STAT:
                    next_s.irq_stat = s.irq_stat & ~wval[6:0];
                `CNLED_REG_IRQ_MASK: next_s.irq_mask = wval[6:0];
                default: next_s.irq_mask = s.irq_mask;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_s.irq_stat = next_s.irq_stat | ev;
        // single millisecond tick for every timer and pattern
        next_s.tick = 1'b0;
        if (s.div >= 17'(TICK_CYCLES - 1)) begin
            next_s.div = 17'h00000;
            next_s.tick = 1'b1;
        end else begin
            next_s.div = s.div + 17'h00001;
        end
        // watchdogs count ms since last message, saturating
        if (guard_rx || !guard_on) begin
            next_s.guard_cnt = 24'h000000;
        end else if (s.tick && !guard_to) begin
            next_s.guard_cnt = s.guard_cnt + 24'h000001;
        end
        if (hb_rx || !hb_on) begin
            next_s.hb_cnt = 16'h0000;
        end else if (s.tick && !hb_to) begin
            next_s.hb_cnt = s.hb_cnt + 16'h0001;
        end
        if (sync_rx || s.sync_period == 16'h0000) begin
            next_s.sync_cnt = 17'h00000;
        end else if (s.tick && !sync_to) begin
            next_s.sync_cnt = s.sync_cnt + 17'h00001;
        end
        if (rpdo_rx || s.event_time == 16'h0000) begin
            next_s.evt_cnt = 16'h0000;
        end else if (s.tick && !evt_to) begin
            next_s.evt_cnt = s.evt_cnt + 16'h0001;
        end
        // a loss holds until the awaited message comes back
        if (guard_rx || hb_rx) begin
            next_s.guard_err = 1'b0;
        end else if (guard_to || hb_to) begin
            next_s.guard_err = 1'b1;
        end
        if (sync_rx) begin
            next_s.sync_err = 1'b0;
        end else if (sync_to) begin
            next_s.sync_err = 1'b1;
        end
        if (rpdo_rx) begin
            next_s.evt_err = 1'b0;
        end else if (evt_to) begin
            next_s.evt_err = 1'b1;
        end
        // ask the stack to fall back once per new loss
        next_s.preop_req = ev[`CNLED_EV_GUARD] || ev[`CNLED_EV_SYNC] ||
            ev[`CNLED_EV_EVENT];
        // bus-off and queue overflow only clear by coupler reset
        next_s.bus_off = s.bus_off || bus_off_event;
        next_s.tx_ovf = s.tx_ovf || tx_queue_ovf;
        next_s.rx_seen = s.rx_seen || rx_queue_ovf;
        // logical overflow hold restarts on every occurrence
        if (tx_logic_ovf) begin
            next_s.ltx_hold = 14'(`CNLED_LTX_HOLD_MS);
        end else if (s.tick && ltx_active) begin
            next_s.ltx_hold = s.ltx_hold - 14'h0001;
        end
        // patterns and their ms counters
        next_s.bus_pat = bus_pat_n;
        next_s.node_pat = node_pat_n;
        next_s.tx_pat = tx_pat_n;
        next_s.rx_pat = rx_pat_n;
        next_s.bus_t = pat_step(s.bus_pat, bus_pat_n, s.bus_t, s.tick);
        next_s.node_t = pat_step(s.node_pat, node_pat_n, s.node_t, s.tick);
        next_s.tx_t = pat_step(s.tx_pat, tx_pat_n, s.tx_t, s.tick);
        next_s.rx_t = pat_step(s.rx_pat, rx_pat_n, s.rx_t, s.tick);
        // lamps registered so they never glitch
        next_s.bus_lamp = pat_lit(s.bus_pat, s.bus_t);
        next_s.node_lamp = pat_lit(s.node_pat, s.node_t);
        next_s.tx_lamp = pat_lit(s.tx_pat, s.tx_t);
        next_s.rx_lamp = pat_lit(s.rx_pat, s.rx_t);
    end

    // state register; synchronous reset models the coupler restart
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

////////////////////////////////////////////////////////////////////////////

    // outputs
    assign waitrequest = bus_req && !s.ack;
    assign readdata = s.rdata;
    assign irq = |(s.irq_stat & s.irq_mask);
    assign preop_request = s.preop_req;
    assign pdo_stop = sup_err || s.bus_off;
    assign outputs_error = sup_err;
    assign can_stop = s.bus_off;
    assign bus_fault_lamp = s.bus_lamp;
    assign node_state_lamp = s.node_lamp;
    assign tx_ovf_lamp = s.tx_lamp;
    assign rx_ovf_lamp = s.rx_lamp;

endmodule // cnled_coder
`default_nettype wire

// ==== rtl/cnled_consts.svh ====
// timing, register offsets and field positions of the status lamp coder
`ifndef CNLED_CONSTS_SVH
`define CNLED_CONSTS_SVH
// clock and millisecond tick
`define CNLED_CLK_PERIOD_NS 10
`define CNLED_TICK_NS 1000000
`define CNLED_TICK_CYCLES (`CNLED_TICK_NS / `CNLED_CLK_PERIOD_NS)
// pattern times in milliseconds
`define CNLED_FAST_MS 50
`define CNLED_BLINK_MS 200
`define CNLED_PAUSE_MS 1000
`define CNLED_LTX_HOLD_MS 10000
// register byte offsets
`define CNLED_REG_CTRL 6'h00
`define CNLED_REG_GUARD_TIME 6'h04
`define CNLED_REG_LIFE_FACTOR 6'h08
`define CNLED_REG_HB_TIME 6'h0C
`define CNLED_REG_SYNC_PERIOD 6'h10
`define CNLED_REG_EVENT_TIME 6'h14
`define CNLED_REG_STATUS 6'h18
`define CNLED_REG_IRQ_STAT 6'h1C
`define CNLED_REG_IRQ_MASK 6'h20
// interrupt / event bit positions
`define CNLED_EV_BUS_OFF 0
`define CNLED_EV_GUARD 1
`define CNLED_EV_SYNC 2
`define CNLED_EV_EVENT 3
`define CNLED_EV_TX_OVF 4
`define CNLED_EV_LTX_OVF 5
`define CNLED_EV_RX_OVF 6
`define CNLED_EV_WIDTH 7
`endif

// ==== rtl/cnled_pkg.sv ====
// types of the status lamp coder
package cnled_pkg;
    typedef enum logic [2:0] {
        PAT_OFF = 3'b000,
        PAT_ON = 3'b001,
        PAT_FAST = 3'b010,
        PAT_SINGLE = 3'b011,
        PAT_EVEN = 3'b100,
        PAT_BLINK2 = 3'b101,
        PAT_BLINK3 = 3'b110,
        PAT_BLINK4 = 3'b111
    } cnled_pat_t;
    typedef enum logic [1:0] {
        NODE_STOPPED = 2'b00,
        NODE_PREOP = 2'b01,
        NODE_OPER = 2'b10
    } cnled_node_t;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic fw_old;
        logic [15:0] guard_time;
        logic [7:0] life_factor;
        logic [15:0] hb_time;
        logic [15:0] sync_period;
        logic [15:0] event_time;
        logic [6:0] irq_stat;
        logic [6:0] irq_mask;
        logic [16:0] div;
        logic tick;
        logic [23:0] guard_cnt;
        logic [15:0] hb_cnt;
        logic [16:0] sync_cnt;
        logic [15:0] evt_cnt;
        logic guard_err;
        logic sync_err;
        logic evt_err;
        logic bus_off;
        logic tx_ovf;
        logic [13:0] ltx_hold;
        logic rx_seen;
        logic preop_req;
        cnled_pat_t bus_pat;
        cnled_pat_t node_pat;
        cnled_pat_t tx_pat;
        cnled_pat_t rx_pat;
        logic [11:0] bus_t;
        logic [11:0] node_t;
        logic [11:0] tx_t;
        logic [11:0] rx_t;
        logic bus_lamp;
        logic node_lamp;
        logic tx_lamp;
        logic rx_lamp;
    } cnled_state_t;
endpackage

// ==== sim/cnled_coder_monitor.sv ====
// port assertions of the status lamp coder
`timescale 1ns/10ps
`default_nettype none
module cnled_coder_monitor (
    // clock, reset and bus
    input wire logic clock,
    input wire logic rst,
    input wire logic read,
    input wire logic waitrequest,
    // conditions
    input wire logic baud_search,
    input wire logic warn_limit,
    input wire logic bus_off_event,
    input wire cnled_pkg::cnled_node_t node_state,
    input wire logic tx_queue_ovf,
    input wire logic rx_queue_ovf,
    // reactions and lamps
    input wire logic preop_request,
    input wire logic pdo_stop,
    input wire logic outputs_error,
    input wire logic can_stop,
    input wire logic bus_fault_lamp,
    input wire logic node_state_lamp,
    input wire logic tx_ovf_lamp,
    input wire logic rx_ovf_lamp
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // four settled cycles cover the two-cycle lamp latency
    sequence s_quiet;
        (!baud_search && !warn_limit && !outputs_error && !can_stop)[*4];
    endsequence
    sequence s_oper;
        (node_state == cnled_pkg::NODE_OPER && !baud_search
            && !outputs_error)[*4];
    endsequence
    sequence s_fallback;
        (outputs_error && pdo_stop) ##1 !preop_request;
    endsequence
    property p_quiet_dark; s_quiet |-> !bus_fault_lamp; endproperty
    property p_search_dark; baud_search[*4] |-> !node_state_lamp; endproperty
    property p_oper_lit; s_oper |-> node_state_lamp; endproperty
    property p_fallback; preop_request |-> s_fallback; endproperty
    property p_err_stop; outputs_error |-> pdo_stop; endproperty
    property p_off_latch; bus_off_event |-> ##[1:2] can_stop; endproperty
    property p_off_hold; can_stop |=> can_stop; endproperty
    property p_off_lamp; can_stop[*4] |-> bus_fault_lamp && pdo_stop; endproperty
    property p_tx_steady; tx_queue_ovf |-> ##4 tx_ovf_lamp[*8]; endproperty
    property p_rx_on; rx_queue_ovf[*4] |-> rx_ovf_lamp; endproperty
    property p_one_wait; $rose(read) |-> waitrequest ##1 !waitrequest; endproperty
    a_quiet_dark: assert property (p_quiet_dark)
        else $error("bus lamp lit");
    a_search_dark: assert property (p_search_dark)
        else $error("node lamp lit");
    a_oper_lit: assert property (p_oper_lit)
        else $error("node lamp dark");
    a_fallback: assert property (p_fallback)
        else $error("no fallback");
    a_err_stop: assert property (p_err_stop)
        else $error("pdo running");
    a_off_latch: assert property (p_off_latch)
        else $error("no bus off");
    a_off_hold: assert property (p_off_hold)
        else $error("bus off lost");
    a_off_lamp: assert property (p_off_lamp)
        else $error("bus lamp dark");
    a_tx_steady: assert property (p_tx_steady)
        else $error("tx lamp dark");
    a_rx_on: assert property (p_rx_on)
        else $error("rx lamp dark");
    a_one_wait: assert property (p_one_wait)
        else $error("no wait state");
endmodule // cnled_coder_monitor
`default_nettype wire

// ==== sim/cnled_lamp_observer.sv ====
// observer that times the lit and dark runs of one lamp
`timescale 1ns/10ps
`default_nettype none
module cnled_lamp_observer (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // lamp and measured runs in cycles
    input wire logic lamp,
    output var logic [31:0] lit_len,
    output var logic [31:0] dark_len
);
    logic [31:0] run;
    logic last;
    ////////////////////////////////////////////////////////////////////////
    // a run is booked only when it ends, so a steady lamp keeps old figures
    always_ff @(posedge clock) begin
        if (rst) begin
            run <= 32'h1;
            last <= 1'b0;
            lit_len <= 32'h0;
            dark_len <= 32'h0;
        end else if (lamp != last) begin
            if (last) lit_len <= run;
            else dark_len <= run;
            run <= 32'h1;
            last <= lamp;
        end else begin
            run <= run + 32'h1;
        end
    end
endmodule // cnled_lamp_observer
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the status lamp coder
`include "cnled_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int TICK = 2;
    localparam int TOL = 2 * TICK + 2;
    logic clock, rst, read, write, irq, waitrequest, baud_search, warn_limit;
    logic bus_off_event, tx_queue_ovf, tx_logic_ovf, rx_queue_ovf;
    logic preop_request, pdo_stop, outputs_error, can_stop;
    logic guard_rx, hb_rx, sync_rx, rpdo_rx;
    logic bus_fault_lamp, node_state_lamp, tx_ovf_lamp, rx_ovf_lamp;
    logic [5:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, s, v, bl, bd, nl, nd, tl, td;
    logic [31:0] exp_q[$], msk_q[$];
    cnled_pkg::cnled_node_t node_state;
    int num_errors, cmp_count;
    ////////////////////////////////////////////////////////////////////////
    cnled_coder #(.TICK_CYCLES(TICK)) i_cnled_coder (.*);
    cnled_lamp_observer i_obs_bus (.clock(clock), .rst(rst),
        .lamp(bus_fault_lamp), .lit_len(bl), .dark_len(bd));
    cnled_lamp_observer i_obs_node (.clock(clock), .rst(rst),
        .lamp(node_state_lamp), .lit_len(nl), .dark_len(nd));
    cnled_lamp_observer i_obs_tx (.clock(clock), .rst(rst),
        .lamp(tx_ovf_lamp), .lit_len(tl), .dark_len(td));
    ////////////////////////////////////////////////////////////////////////
    // compare; zero tolerance is exact, unknowns always fail
    task automatic chk(input string n, input logic [31:0] e, g, input int t);
        cmp_count++;
        if (^g === 1'bx || (t == 0 && g !== e) ||
            (t > 0 && (g + t < e || g > e + t))) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // one avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do @(posedge clock); while (waitrequest);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    // expected bus, node, tx, rx patterns
    task automatic st(input logic [2:0] b, n, t, r);
        rd(`CNLED_REG_STATUS, {16'h0, 1'b0, r, 1'b0, t, 1'b0, n, 1'b0, b},
           32'h7777);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // read data judged at the answering edge
    always @(posedge clock) begin
        if (read && !waitrequest) begin
            chk("readdata", exp_q.pop_front(), readdata & msk_q.pop_front(), 0);
        end
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // watchdog, twice the run
    initial begin
        cyc(95000);
        num_errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        {read, write, address, byteenable, writedata} = '0;
        {baud_search, warn_limit, bus_off_event} = 3'h0;
        {tx_queue_ovf, tx_logic_ovf, rx_queue_ovf} = 3'h0;
        {guard_rx, hb_rx, sync_rx, rpdo_rx} = 4'h0;
        node_state = cnled_pkg::NODE_STOPPED;
        num_errors = 0;
        cmp_count = 0;
        s = 32'd97;
        rst = 1'b1;
        cyc(5);
        rst <= 1'b0;
        st(3'h0, 3'h3, 3'h0, 3'h0);
        rd(6'h3C, 32'h0, 32'hFFFFFFFF);
        wr(`CNLED_REG_IRQ_MASK, 32'h7F);
        s = xs(s);
        v = s;
        bus(1'b1, `CNLED_REG_GUARD_TIME, v, s[7:4]);
        rd(`CNLED_REG_GUARD_TIME, {16'h0, s[5] ? v[15:8] : 8'h00,
           s[4] ? v[7:0] : 8'h00}, 32'hFFFF);
        wr(`CNLED_REG_STATUS, 32'hFFFFFFFF);
        cyc(200);
        st(3'h0, 3'h3, 3'h0, 3'h0);
        chk("irq", 1'b0, irq, 0);
        wr(`CNLED_REG_CTRL, 32'h1);
        cyc(10);
        st(3'h0, 3'h0, 3'h0, 3'h0);
        wr(`CNLED_REG_CTRL, 32'h0);
        baud_search <= 1'b1;
        cyc(600);
        st(3'h2, 3'h0, 3'h0, 3'h0);
        chk("fast lit", 50 * TICK, bl, TOL);
        chk("fast dark", 50 * TICK, bd, TOL);
        baud_search <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            node_state <= cnled_pkg::cnled_node_t'(i);
            cyc(1200);
            st(3'h0, i == 0 ? 3'h3 : i == 1 ? 3'h4 : 3'h1, 3'h0,
               3'h0);
            if (i == 1) chk("preop lit", 200 * TICK, nl, TOL);
            if (i == 1) chk("preop dark", 200 * TICK, nd, TOL);
        end
        warn_limit <= 1'b1;
        cyc(5300);
        st(3'h3, 3'h1, 3'h0, 3'h0);
        chk("warn lit", 200 * TICK, bl, TOL);
        chk("warn dark", 1000 * TICK, bd, TOL);
        warn_limit <= 1'b0;
        cyc(5);
        st(3'h0, 3'h1, 3'h0, 3'h0);
        wr(`CNLED_REG_LIFE_FACTOR, 32'h2);
        wr(`CNLED_REG_GUARD_TIME, 32'h5);
        cyc(80);
        st(3'h5, 3'h4, 3'h0, 3'h0);
        chk("irq", 1'b1, irq, 0);
        rd(`CNLED_REG_IRQ_STAT, 32'h2, 32'h2);
        wr(`CNLED_REG_IRQ_STAT, 32'h2);
        cyc(2);
        chk("irq", 1'b0, irq, 0);
        wr(`CNLED_REG_IRQ_MASK, 32'h0);
        wr(`CNLED_REG_SYNC_PERIOD, 32'h4);
        cyc(80);
        st(3'h6, 3'h4, 3'h0, 3'h0);
        chk("irq", 1'b0, irq, 0);
        rd(`CNLED_REG_IRQ_STAT, 32'h4, 32'h6);
        wr(`CNLED_REG_IRQ_MASK, 32'h7F);
        cyc(2);
        chk("irq", 1'b1, irq, 0);
        wr(`CNLED_REG_EVENT_TIME, 32'h3);
        cyc(80);
        st(3'h7, 3'h4, 3'h0, 3'h0);
        {guard_rx, hb_rx, sync_rx, rpdo_rx} <= 4'hF;
        cyc(1);
        {guard_rx, hb_rx, sync_rx, rpdo_rx} <= 4'h0;
        cyc(1);
        chk("outputs_error", 1'b0, outputs_error, 0);
        bus_off_event <= 1'b1;
        cyc(1);
        bus_off_event <= 1'b0;
        cyc(10);
        st(3'h1, 3'h4, 3'h0, 3'h0);
        chk("can_stop", 1'b1, can_stop, 0);
        tx_logic_ovf <= 1'b1;
        cyc(1);
        tx_logic_ovf <= 1'b0;
        cyc(14000);
        st(3'h1, 3'h4, 3'h4, 3'h0);
        chk("ltx lit", 200 * TICK, tl, TOL);
        chk("ltx dark", 200 * TICK, td, TOL);
        tx_logic_ovf <= 1'b1;
        cyc(1);
        tx_logic_ovf <= 1'b0;
        cyc(15000);
        st(3'h1, 3'h4, 3'h4, 3'h0);
        cyc(6000);
        st(3'h1, 3'h4, 3'h0, 3'h0);
        tx_queue_ovf <= 1'b1;
        cyc(1);
        tx_queue_ovf <= 1'b0;
        cyc(100);
        st(3'h1, 3'h4, 3'h1, 3'h0);
        rx_queue_ovf <= 1'b1;
        cyc(10);
        st(3'h1, 3'h4, 3'h1, 3'h1);
        rx_queue_ovf <= 1'b0;
        cyc(10);
        st(3'h1, 3'h4, 3'h1, 3'h4);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(10);
        st(3'h0, 3'h1, 3'h0, 3'h0);
        chk("can_stop", 1'b0, can_stop, 0);
        report_and_stop();
    end
endmodule // tb_top
bind cnled_coder cnled_coder_monitor i_cnled_coder_monitor (.*);
`default_nettype wire
